// ---- hdl/iqwp_pkg.sv ----
// Functional notes
// RULE_01: two 2k by 16-bit I/Q buffers, processor-written
// RULE_02: trigger plays both buffers together, one sample/clock
// RULE_03: internal trigger mode repeats playback continuously
// RULE_04: playback starts on edge trigger is recognised
// RULE_05: start uncertainty at most one clock period
// RULE_06: trigger pulse is 100 ns wide
// RULE_07: trigger timing placed in 2.1 ns steps
// RULE_08: operator centres trigger between the two jumps
// RULE_09: eight-channel 14-bit slow ADC over serial link
// RULE_10: each ADC channel into own readable 16-bit register
// RULE_11: channels: three temperatures, four supplies, RF power
// RULE_12: calibration or operating mode selects source waveforms
// RULE_13: calibration buffer is cal samples times gain plus offset
// RULE_14: operating buffer is samples times gain, adjust, plus offset
// RULE_15: new settings anytime, take effect on next trigger; code writes go straight into the buffer being played
// RULE_16: calibration loads cosine and sine for single sideband
// RULE_17: trigger synchronised, one start per pulse rising edge
// RULE_18: triggered pass walks 2048 addresses then holds
package iqwp_pkg;
    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int DEPTH = 2048;
    localparam int AW = 11;
    localparam int DW = 16;
    localparam logic [AW-1:0] LAST_ADDR = 11'h7FF;
    // ------------------------------------------------------------
    // processor map (word addresses)
    // ------------------------------------------------------------
    localparam int BUS_AW = 13;
    localparam logic [1:0] REGION_I = 2'h0;
    localparam logic [1:0] REGION_Q = 2'h1;
    localparam logic [1:0] REGION_REG = 2'h2;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_ADC0 = 4'h8;
    localparam int CTRL_INT_TRIG = 0;
    localparam int CTRL_CAL_MODE = 1;
    localparam logic [DW-1:0] CTRL_RESET = 16'h0000;
    // ------------------------------------------------------------
    // slow adc serial timing
    // ------------------------------------------------------------
    localparam int ADC_CH = 8;
    localparam int ADC_BITS = 14;
    localparam int CLK_MHZ = 102;
    localparam real SCLK_MHZ = 10.0;
    localparam int SCLK_HALF = int'($ceil(CLK_MHZ / (2.0 * SCLK_MHZ)));
    localparam int FRAME_BITS = 16;
    localparam real CLK_NS = 9.8;
    localparam int JITTER_CYC = int'($floor(9.8 / CLK_NS));
endpackage

// ---- hdl/iqwp_adc_serial.sv ----
`timescale 1ns/100ps
module iqwp_adc_serial (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // serial converter pins
    output logic adc_sclk,
    output logic adc_cs_n,
    output logic adc_din,
    input wire logic adc_dout,
    // results
    output logic [2:0] res_ch,
    output logic [15:0] res_data,
    output logic res_valid
);
    // ------------------------------------------------------------
    // divider, frame counter
    // ------------------------------------------------------------
    logic [7:0] div;
    logic [4:0] bitn;
    logic [2:0] ch;
    logic [15:0] shreg;
    logic dout_s1, dout_s2;
    wire tick = (div == 8'(iqwp_pkg::SCLK_HALF - 1));
    wire rise = tick && !adc_sclk;
    wire frame_end = rise && (bitn == 5'(iqwp_pkg::FRAME_BITS - 1));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dout_s1 <= 1'b0;
            dout_s2 <= 1'b0;
        end else begin
            dout_s1 <= adc_dout;
            dout_s2 <= dout_s1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div <= 8'h00;
            adc_sclk <= 1'b0;
            adc_cs_n <= 1'b1;
            adc_din <= 1'b0;
            bitn <= 5'h00;
            ch <= 3'h0;
            shreg <= 16'h0000;
            res_valid <= 1'b0;
            res_ch <= 3'h0;
            res_data <= 16'h0000;
        end else begin
            res_valid <= 1'b0;
            div <= tick ? 8'h00 : div + 8'h01;
            if (tick) begin
                adc_cs_n <= 1'b0;
                adc_sclk <= !adc_sclk;
                // channel select shifts out msb first
                adc_din <= (bitn < 5'h3) ? ch[2 - bitn[1:0]] : 1'b0;
            end
            if (rise && !adc_cs_n) begin
                shreg <= {shreg[14:0], dout_s2}; // [RULE_09]
                bitn <= frame_end ? 5'h00 : bitn + 5'h01;
            end
            if (frame_end && !adc_cs_n) begin
                res_valid <= 1'b1;
                res_ch <= ch;
                // 14 significant bits, zero-extended
                res_data <= {2'h0, shreg[12:0], dout_s2}; // [RULE_10]
                ch <= ch + 3'h1;
            end
        end
    end
endmodule

// ---- hdl/iqwp_top.sv ----
`timescale 1ns/100ps
module iqwp_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // processor memory port
    input wire logic cpu_sel,
    input wire logic cpu_wr,
    input wire logic [12:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    // timing trigger pin
    input wire logic trig_in,
    // dual dac
    output logic [15:0] dac_i,
    output logic [15:0] dac_q,
    output logic dac_active,
    // slow adc
    output logic adc_sclk,
    output logic adc_cs_n,
    output logic adc_din,
    input wire logic adc_dout
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [15:0] buf_i [iqwp_pkg::DEPTH];
    logic [15:0] buf_q [iqwp_pkg::DEPTH];
    logic [15:0] adc_res [iqwp_pkg::ADC_CH];
    logic [15:0] ctrl;
    logic [10:0] play_addr;
    logic playing;
    logic trig_s1, trig_s2, trig_s3;
    wire [1:0] region = cpu_addr[12:11];
    wire [10:0] waddr = cpu_addr[10:0];
    wire wr_i = cpu_sel && cpu_wr && region == iqwp_pkg::REGION_I;
    wire wr_q = cpu_sel && cpu_wr && region == iqwp_pkg::REGION_Q;
    wire reg_hit = region == iqwp_pkg::REGION_REG;
    wire wr_ctrl = cpu_sel && cpu_wr && reg_hit
        && cpu_addr[3:0] == iqwp_pkg::OFS_CTRL;
    wire int_trig = ctrl[iqwp_pkg::CTRL_INT_TRIG];
    wire trig_edge = trig_s2 && !trig_s3; // [RULE_17]
    wire start = !playing && (trig_edge || int_trig); // [RULE_18]
    wire last = play_addr == iqwp_pkg::LAST_ADDR;
    wire [2:0] res_ch;
    wire [15:0] res_data;
    wire res_valid;
    logic [15:0] next_rdata;

    // ------------------------------------------------------------
    // buffers: writes allowed any time, straight into the buffer being played
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (wr_i) begin
            buf_i[waddr] <= cpu_wdata; // [RULE_01] [RULE_15]
        end
        if (wr_q) begin
            buf_q[waddr] <= cpu_wdata; // [RULE_01]
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= iqwp_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            // cal-mode bit only tags which source software computes
            ctrl <= cpu_wdata; // [RULE_12]
        end
    end

    // ------------------------------------------------------------
    // trigger sync and playback
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else begin
            trig_s1 <= trig_in;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2; // [RULE_05]
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            playing <= 1'b0;
            play_addr <= 11'h000;
        end else if (start) begin
            playing <= 1'b1; // [RULE_04]
            play_addr <= 11'h000;
        end else if (playing) begin
            playing <= !last; // [RULE_18]
            play_addr <= last ? 11'h000 : play_addr + 11'h001;
        end
    end

    // internal mode restarts right after the pass, so output repeats
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dac_i <= 16'h0000;
            dac_q <= 16'h0000;
            dac_active <= 1'b0;
        end else begin
            dac_active <= playing; // [RULE_03]
            if (playing) begin
                dac_i <= buf_i[play_addr]; // [RULE_02]
                dac_q <= buf_q[play_addr]; // [RULE_02]
            end
        end
    end

    // ------------------------------------------------------------
    // slow adc results
    // ------------------------------------------------------------
    iqwp_adc_serial u_adc (
        .clock(clock),
        .rst_n(rst_n),
        .adc_sclk(adc_sclk),
        .adc_cs_n(adc_cs_n),
        .adc_din(adc_din),
        .adc_dout(adc_dout),
        .res_ch(res_ch),
        .res_data(res_data),
        .res_valid(res_valid)
    );

    // ch0-2 temperatures, ch3-6 supplies, ch7 rf power
    genvar g;
    generate
        for (g = 0; g < iqwp_pkg::ADC_CH; g++) begin : g_res
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    adc_res[g] <= 16'h0000;
                end else if (res_valid && res_ch == 3'(g)) begin
                    adc_res[g] <= res_data; // [RULE_10] [RULE_11]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux: registers only, buffers are write-only
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_hit && cpu_addr[3]) begin
            next_rdata = adc_res[cpu_addr[2:0]]; // [RULE_10]
        end else if (reg_hit && cpu_addr[3:0] == iqwp_pkg::OFS_CTRL) begin
            next_rdata = ctrl;
        end else if (reg_hit && cpu_addr[3:0] == iqwp_pkg::OFS_STATUS) begin
            next_rdata = {4'h0, playing, play_addr};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= 16'h0000;
        end else if (cpu_sel && !cpu_wr) begin
            cpu_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    start_play_a: assert property (@(posedge clock) disable iff (!rst_n)
        start |=> playing && play_addr == 11'h000) // [RULE_04]
        else $error("playback did not start");
    pass_len_a: assert property (@(posedge clock) disable iff (!rst_n)
        (playing && last) |=> !playing) // [RULE_18]
        else $error("pass did not end at last address");
    step_addr_a: assert property ( // [RULE_02]
        @(posedge clock) disable iff (!rst_n)
        (playing && !last) |=> play_addr == $past(play_addr) + 11'h001)
        else $error("address did not step");
    no_retrig_a: assert property ( // [RULE_18]
        @(posedge clock) disable iff (!rst_n)
        (playing && !last && trig_edge) |=> play_addr != 11'h000)
        else $error("retrigger during pass");
    // a pulse still high after the pass must not start another one
    edge_once_a: assert property ( // [RULE_17]
        @(posedge clock) disable iff (!rst_n)
        (!playing && !int_trig && trig_s2 && trig_s3) |=> !playing)
        else $error("held trigger restarted playback");
    int_repeat_a: assert property (@(posedge clock) disable iff (!rst_n)
        (int_trig && !playing) |=> playing) // [RULE_03]
        else $error("internal mode did not restart");
    dac_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        playing |=> dac_active) // [RULE_02]
        else $error("dac not active");
    adc_store_a: assert property ( // [RULE_10]
        @(posedge clock) disable iff (!rst_n)
        (res_valid && res_ch == 3'h7) |=> adc_res[7] == $past(res_data))
        else $error("adc result not stored");
    ext_start_c: cover property (@(posedge clock) trig_edge && !playing);
    full_pass_c: cover property (@(posedge clock) playing && last);
    int_mode_c: cover property (@(posedge clock) int_trig && start);
    adc_done_c: cover property (@(posedge clock) res_valid);
endmodule

// ---- verification/iqwp_partner.sv ----
`timescale 1ns/100ps
module iqwp_partner #(
    parameter logic [13:0] ADC_VAL = 14'h2A5C
) (
    // clock
    input wire logic clock,
    // trigger source
    output logic trig_in,
    // dual dac
    input wire logic dac_active,
    output int samples,
    // slow adc
    input wire logic adc_sclk,
    input wire logic adc_cs_n,
    input wire logic adc_din,
    output logic adc_dout
);
    logic [3:0] n = 4'h0;
    logic [2:0] fr = 3'h0;
    logic q = 1'b0;
    // each frame carries its own channel value so mix-ups show
    wire [15:0] word = {2'h0, ADC_VAL + 14'(fr)};
    initial trig_in = 1'b0;
    initial samples = 0;
    // ------------------------------------------------------------
    // trigger: 100 ns pulse, placed in 2.1 ns steps
    // ------------------------------------------------------------
    task automatic fire(input int steps);
        #(2.1 * steps);
        trig_in = 1'b1;
        #100.0;
        trig_in = 1'b0;
    endtask
    always @(posedge clock) if (dac_active) samples <= samples + 1;
    // ------------------------------------------------------------
    // converter: msb first, shifted on falling sclk
    // ------------------------------------------------------------
    // select stays low, so frames are counted as 16 falling edges
    always @(negedge adc_sclk) begin
        if (!adc_cs_n) begin
            q <= word[4'hF - n];
            n <= n + 4'h1;
            if (n == 4'hF) begin
                fr <= fr + 3'h1;
            end
        end
    end
    // released line shows inverse, not a stale bit
    assign adc_dout = adc_cs_n ? ~q : q;
endmodule

// ---- verification/iqwp_top_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
 miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module iqwp_top_tb;
    localparam logic [13:0] ADC_VAL = 14'h2A5C;
    logic clock = 0, rst_n = 0, cpu_sel = 0, cpu_wr = 0;
    logic [12:0] cpu_addr = 13'h0000;
    logic [15:0] cpu_wdata = 16'h0000, cpu_rdata, dac_i, dac_q, rd;
    logic trig_in, dac_active, adc_sclk, adc_cs_n, adc_din, adc_dout;
    int miscompares = 0, checks_done = 0, k, i;
    always #2 clock = ~clock;
    iqwp_top iqwp_top_inst(.clock(clock), .rst_n(rst_n),
        .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .trig_in(trig_in),
        .dac_i(dac_i), .dac_q(dac_q), .dac_active(dac_active),
        .adc_sclk(adc_sclk), .adc_cs_n(adc_cs_n), .adc_din(adc_din),
        .adc_dout(adc_dout));
    iqwp_partner #(.ADC_VAL(ADC_VAL)) iqwp_partner_inst(.clock(clock),
        .trig_in(trig_in), .dac_active(dac_active), .samples(),
        .adc_sclk(adc_sclk), .adc_cs_n(adc_cs_n), .adc_din(adc_din),
        .adc_dout(adc_dout));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [12:0] a,
                       input logic [15:0] d);
        @(posedge clock);
        cpu_sel <= 1'b1;
        cpu_wr <= w;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge clock);
        cpu_sel <= 1'b0;
        cpu_wr <= 1'b0;
        @(posedge clock);
        #1 rd = cpu_rdata;
    endtask
    function automatic logic [15:0] wave(input int s, input int g,
                                         input int a, input int o);
        return 16'(s * g * a + o);
    endfunction
    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_active(output int n);
        n = 0;
        while (dac_active !== 1'b1) begin
            @(posedge clock);
            #1 n++;
            if (n > 40) begin
                `CHK("dac_active", 1'b1, 1'b0)
                finish_test;
            end
        end
    endtask
    task automatic run_out;
        k = 0;
        while (dac_active === 1'b1 && k < 3000) begin
            @(posedge clock);
            #1 k++;
        end
        if (k >= 3000) begin
            `CHK("run_out", 1'b0, dac_active)
            finish_test;
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_regs;
        bus(1'b0, 13'h1000, 16'h0000);
        `CHK("ctrl reset", iqwp_pkg::CTRL_RESET, rd)
        bus(1'b1, 13'h1000, 16'h0002);
        bus(1'b0, 13'h1000, 16'h0000);
        `CHK("ctrl mode", 16'h0002, rd)
        bus(1'b0, 13'h0005, 16'h0000);
        `CHK("buffer read", 16'h0000, rd)
        bus(1'b0, 13'h1FFF, 16'h0000);
        `CHK("unmapped", 16'h0000, rd)
        bus(1'b1, 13'h1000, 16'h0000);
        $display("test_regs done");
    endtask
    task automatic test_trig;
        for (i = 0; i < 2048; i++) begin
            // operating mode: gain 2, adjust 1, offset 1
            bus(1'b1, 13'(i), wave(i, 2, 1, 1));
            bus(1'b1, 13'h0800 | 13'(i), ~16'(i));
        end
        @(posedge clock);
        // one step lands near mid-period, clear of the sample edge
        fork iqwp_partner_inst.fire(1); join_none
        wait_active(k);
        `CHK("latency", 4, k)
        for (i = 0; i < 2048; i++) begin
            if (i > 0) begin
                @(posedge clock);
                #1;
            end
            // triggers mid-pass and across the pass end must not restart
            if (i == 100 || i == 2040) begin
                fork iqwp_partner_inst.fire(0); join_none
            end
            `CHK("dac_i", wave(i, 2, 1, 1), dac_i)
            `CHK("dac_q", ~16'(i), dac_q)
        end
        @(posedge clock);
        #1 `CHK("pass end", 1'b0, dac_active)
        repeat (40) @(posedge clock);
        #1 `CHK("no retrigger", 1'b0, dac_active)
        `CHK("hold", ~16'h07FF, dac_q)
        `CHK("dac count", 2048, iqwp_partner_inst.samples)
        bus(1'b0, 13'h1001, 16'h0000);
        `CHK("status idle", 16'h0000, rd)
        $display("test_trig done");
    endtask
    task automatic test_internal;
        // calibration: cosine and sine at zero, gain 2, offset 1
        bus(1'b1, 13'h0000, wave(16'h5F77, 2, 1, 1));
        bus(1'b1, 13'h0800, wave(0, 2, 1, 1));
        bus(1'b1, 13'h1000, 16'h0003);
        wait_active(k);
        `CHK("new sample", 16'hBEEF, dac_i)
        `CHK("sine sample", 16'h0001, dac_q)
        run_out;
        `CHK("pass length", 2048, k)
        @(posedge clock);
        #1 `CHK("repeat", 1'b1, dac_active)
        bus(1'b1, 13'h1000, 16'h0000);
        run_out;
        repeat (10) @(posedge clock);
        #1 `CHK("stopped", 1'b0, dac_active)
        $display("test_internal done");
    endtask
    task automatic test_adc;
        k = 0;
        do begin
            bus(1'b0, 13'h100F, 16'h0000);
            k++;
        end while (rd !== {2'h0, ADC_VAL + 14'h7} && k < 3000);
        if (k >= 3000) begin
            `CHK("adc poll", 1'b1, 1'b0)
            finish_test;
        end
        bus(1'b1, 13'h1008, 16'hFFFF);
        for (i = 0; i < 8; i++) begin
            bus(1'b0, 13'h1008 + 13'(i), 16'h0000);
            `CHK("adc ch", {2'h0, ADC_VAL + 14'(i)}, rd)
        end
        $display("test_adc done");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        test_regs;
        test_trig;
        test_internal;
        test_adc;
        finish_test;
    end
endmodule
